// ==== dci_cfg.svh ====
// constants for the debug command interpreter
`ifndef DCI_CFG_SVH
`define DCI_CFG_SVH
`define DCI_CMD_REV      8'h00
`define DCI_CMD_STAT     8'h02
`define DCI_CMD_CTLW     8'h04
`define DCI_CMD_CTLR     8'h05
`define DCI_CMD_PCW      8'h06
`define DCI_CMD_PCR      8'h07
`define DCI_CMD_REGW     8'h08
`define DCI_CMD_REGR     8'h09
`define DCI_CMD_PMW      8'h0a
`define DCI_CMD_PMR      8'h0b
`define DCI_CMD_DMW      8'h0c
`define DCI_CMD_DMR      8'h0d
`define DCI_CMD_CRC      8'h0e
`define DCI_CMD_STEP     8'h10
`define DCI_CMD_STUFF    8'h11
`define DCI_CMD_EXEC     8'h12
`define DCI_CTL_HALT_BIT 7
`define DCI_CTL_RESET    8'h00
`define DCI_ALL_ONES     8'hff
`define DCI_CRC_INIT     16'hffff
`define DCI_CRC_POLY     16'h1021
`define DCI_REV_WORD     16'h0100
`define DCI_FLASH_LO     12'hff8
`define DCI_FLASH_HI     12'hfff
`endif

// ==== dci_pkg.sv ====
// types for the debug command interpreter
package dci_pkg;
    typedef enum logic [3:0] {
        DCI_IDLE, DCI_OPER, DCI_DATA, DCI_REPLY, DCI_CRC, DCI_INSTR
    } dci_state_t;
    typedef enum logic [1:0] {
        DCI_SP_REG, DCI_SP_PROG, DCI_SP_DATA
    } dci_space_t;
endpackage

// ==== dci_crc16.sv ====
// crc-ccitt byte update step
`timescale 1ns/10ps
`include "dci_cfg.svh"
module dci_crc16 (
    input  wire logic [15:0] crc_i,
    input  wire logic [7:0]  byte_i,
    output logic      [15:0] crc_o
);
    // eight serial shifts, msb first
    always_comb begin
        logic [15:0] c;
        c = crc_i;
        for (int i = 7; i >= 0; i--) begin
            if (c[15] ^ byte_i[i]) begin
                c = {c[14:0], 1'b0} ^ `DCI_CRC_POLY;
            end else begin
                c = {c[14:0], 1'b0};
            end
        end
        crc_o = c;
    end
endmodule

// ==== dci_core.sv ====
// debug command interpreter: host byte stream to cpu and memory access
//
// Overview of operation
// (R01) command 00h returns the 16-bit revision word, major byte first.
// (R02) command 02h returns the 8-bit debugger status register.
// (R03) command 04h takes one byte into the debugger control register.
// (R04) under protection a control write may set the halt bit only.
// (R05) command 05h returns the debugger control register.
// (R06) command 06h loads pc high then low; discarded unless halted, open.
// (R07) command 07h returns pc high then low, or ffffh when gated.
// (R08) register write: cmd, address high nibble, address low, size, data.
// (R09) register writes dropped when running; protected allows flash regs only.
// (R10) register read uses same framing; bytes are ffh when gated.
// (R11) program write: 16-bit address, size; needs unlock, halt, no protect.
// (R12) program read same framing; bytes ffh when not halted or protected.
// (R13) data write: 16-bit address and size; dropped when gated.
// (R14) data read same framing; bytes ffh only when not halted.
// (R15) command 0eh returns crc-ccitt of program memory, ffffh if running.
// (R16) crc reply comes after whole memory read, one memory access per byte.
// (R17) step runs one instruction at pc; ignored when gated.
// (R18) stuff runs one instruction with host first byte; ignored when gated.
// (R19) execute runs a host-sent 2-5 byte instruction; ignored when gated.
// (R20) while the halt bit is set the cpu stops fetching.
// (R21) readout protection blocks program memory readout commands.
// (R22) host sends no new command until the current one completes.
// (R23) block transfers increment address per byte until size runs out.
`timescale 1ns/10ps
`include "dci_cfg.svh"
module dci_core #(
    parameter int PM_AW = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        rx_valid_i,   // host byte in
    input  wire logic [7:0]  rx_data_i,
    output logic             tx_valid_o,   // reply byte out
    output logic      [7:0]  tx_data_o,
    input  wire logic        tx_ready_i,
    input  wire logic        protect_i,    // readout protection option
    input  wire logic        flash_unlock_i,
    input  wire logic [7:0]  status_i,     // debugger status register
    output logic             halt_o,       // cpu stops fetching
    output logic      [7:0]  ctl_o,
    input  wire logic [15:0] pc_i,
    output logic             pc_we_o,
    output logic      [15:0] pc_o,
    output logic             mem_req_o,    // memory access strobe
    output logic             mem_we_o,
    output dci_pkg::dci_space_t mem_space_o,
    output logic      [15:0] mem_addr_o,
    output logic      [7:0]  mem_wdata_o,
    input  wire logic        mem_ack_i,
    input  wire logic [7:0]  mem_rdata_i,
    output logic             step_o,       // run one instruction at pc
    output logic             exec_o,       // run instr from instr bytes
    output logic             stuff_o,      // first byte given, rest fetched
    output logic      [39:0] instr_o,
    output logic      [2:0]  instr_len_o,
    input  wire logic        cpu_done_i
);
    import dci_pkg::*;

    // refuse widths that the 17-bit byte counter cannot serve
    if (PM_AW < 1 || PM_AW > 16) begin : g_bad_aw
        $error("PM_AW must be 1..16");
    end

    ////////////////////////////////////////////////////////////////////////
    // instruction length by opcode low nibble, except opcode 1fh which is five bytes
    function automatic logic [2:0] op_len(input logic [7:0] op);
        case (op[3:0])
            4'hf, 4'hd: op_len = 3'd3;
            4'hc, 4'he: op_len = 3'd2;
            4'h0, 4'h1: op_len = 3'd2;
            4'h8, 4'h9: op_len = 3'd4;
            default:    op_len = 3'd2;
        endcase
        if (op == 8'h1f) op_len = 3'd5;
    endfunction

    typedef struct packed {
        dci_state_t  st;
        logic [7:0]  cmd;
        logic [7:0]  ctl;
        logic [2:0]  opn;      // operand byte index
        logic [15:0] addr;
        logic [16:0] cnt;      // bytes left
        logic [15:0] word;     // two-byte reply or pc load
        logic [1:0]  nrep;     // reply bytes left for word replies
        logic        gate;     // access gated for this command
        logic        busy;     // memory request or cpu instruction outstanding
        logic [7:0]  rdat;
        logic [15:0] crc;
        logic [39:0] ins;
        logic [2:0]  ilen;
        logic [2:0]  ipos;
        logic        go;
        logic        txv;
        logic [7:0]  txd;
        logic        pcwe;
        logic        req;
        logic        we;
        logic [7:0]  wd;
    } dci_core_t;

    dci_core_t s_r, s_nxt;
    logic [15:0] crc_upd;
    logic halted, locked;

    assign halted = s_r.ctl[`DCI_CTL_HALT_BIT];
    assign locked = !halted || protect_i;

    dci_crc16 u_crc (
        .crc_i  (s_r.crc),
        .byte_i (mem_rdata_i),
        .crc_o  (crc_upd)
    );

    function automatic logic is_mem(input logic [7:0] c);
        is_mem = (c >= `DCI_CMD_REGW && c <= `DCI_CMD_DMR);
    endfunction

    function automatic logic is_wr(input logic [7:0] c);
        is_wr = !c[0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    always_comb begin
        s_nxt = s_r;
        s_nxt.pcwe = 1'b0;
        s_nxt.go = 1'b0;
        if (s_r.txv && tx_ready_i) s_nxt.txv = 1'b0;
        case (s_r.st)
            DCI_IDLE: begin
                if (rx_valid_i) begin
                    s_nxt.cmd = rx_data_i;
                    s_nxt.opn = 3'd0;
                    s_nxt.cnt = '0;
                    case (rx_data_i)
                        // (R01) revision word
                        `DCI_CMD_REV: begin
                            s_nxt.word = `DCI_REV_WORD;
                            s_nxt.nrep = 2'd2;
                            s_nxt.st = DCI_REPLY;
                        end
                        // (R02) status byte
                        `DCI_CMD_STAT: begin
                            s_nxt.word = {status_i, 8'h00};
                            s_nxt.nrep = 2'd1;
                            s_nxt.st = DCI_REPLY;
                        end
                        // (R05) control byte
                        `DCI_CMD_CTLR: begin
                            s_nxt.word = {s_r.ctl, 8'h00};
                            s_nxt.nrep = 2'd1;
                            s_nxt.st = DCI_REPLY;
                        end
                        // (R07) pc readback gated to ffffh
                        `DCI_CMD_PCR: begin
                            s_nxt.word = locked ? 16'hffff : pc_i;
                            s_nxt.nrep = 2'd2;
                            s_nxt.st = DCI_REPLY;
                        end
                        // (R15) crc scan, ffffh when running
                        `DCI_CMD_CRC: begin
                            s_nxt.crc = `DCI_CRC_INIT;
                            s_nxt.addr = '0;
                            s_nxt.cnt = 17'(1) << PM_AW;
                            if (!halted) begin
                                s_nxt.word = 16'hffff;
                                s_nxt.nrep = 2'd2;
                                s_nxt.st = DCI_REPLY;
                            end else begin
                                s_nxt.st = DCI_CRC;
                            end
                        end
                        // (R17) step one instruction
                        `DCI_CMD_STEP: begin
                            if (!locked) s_nxt.st = DCI_INSTR;
                            s_nxt.ilen = 3'd0;
                        end
                        `DCI_CMD_CTLW, `DCI_CMD_PCW, `DCI_CMD_STUFF,
                        `DCI_CMD_EXEC: s_nxt.st = DCI_OPER;
                        default: begin
                            if (is_mem(rx_data_i)) s_nxt.st = DCI_OPER;
                        end
                    endcase
                end
            end
            DCI_OPER: begin
                if (rx_valid_i) begin
                    s_nxt.opn = s_r.opn + 3'd1;
                    case (s_r.cmd)
                        `DCI_CMD_CTLW: begin
                            // (R03) load control register
                            s_nxt.ctl = rx_data_i;
                            // (R04) halt bit cannot clear when protected
                            if (protect_i) begin
                                s_nxt.ctl[`DCI_CTL_HALT_BIT] =
                                    rx_data_i[`DCI_CTL_HALT_BIT] | halted;
                            end
                            s_nxt.st = DCI_IDLE;
                        end
                        `DCI_CMD_PCW: begin
                            // (R06) pc high then low, dropped when gated
                            s_nxt.word = {s_r.word[7:0], rx_data_i};
                            if (s_r.opn == 3'd1) begin
                                s_nxt.pcwe = !locked;
                                s_nxt.st = DCI_IDLE;
                            end
                        end
                        `DCI_CMD_STUFF, `DCI_CMD_EXEC: begin
                            // (R18) (R19) gather opcode bytes
                            s_nxt.ins = {s_r.ins[31:0], rx_data_i};
                            if (s_r.opn == 3'd0) begin
                                s_nxt.ins = {32'h0, rx_data_i};
                                s_nxt.ilen = (s_r.cmd == `DCI_CMD_STUFF)
                                    ? 3'd1 : op_len(rx_data_i);
                            end
                            if (s_r.opn == 3'd0 && s_r.cmd == `DCI_CMD_STUFF
                                || s_r.opn + 3'd1 == s_nxt.ilen) begin
                                s_nxt.st = locked ? DCI_IDLE : DCI_INSTR;
                            end
                        end
                        default: begin
                            // (R08) (R11) address and size framing
                            if (s_r.cmd[7:1] == 7'h04) begin
                                case (s_r.opn)
                                    3'd0: s_nxt.addr = {4'h0,
                                        rx_data_i[3:0], 8'h00};
                                    3'd1: s_nxt.addr[7:0] = rx_data_i;
                                    default: s_nxt.cnt = (rx_data_i == 8'h00)
                                        ? 17'd256 : {9'h0, rx_data_i};
                                endcase
                                if (s_r.opn == 3'd2) s_nxt.st = DCI_DATA;
                            end else begin
                                case (s_r.opn)
                                    3'd0: s_nxt.addr[15:8] = rx_data_i;
                                    3'd1: s_nxt.addr[7:0] = rx_data_i;
                                    3'd2: s_nxt.cnt[15:8] = rx_data_i;
                                    default: s_nxt.cnt[7:0] = rx_data_i;
                                endcase
                                if (s_r.opn == 3'd3) begin
                                    if (s_nxt.cnt[15:0] == 16'h0)
                                        s_nxt.cnt = 17'h10000;
                                    s_nxt.st = DCI_DATA;
                                end
                            end
                        end
                    endcase
                end
            end
            DCI_DATA: begin
                // gating for this transfer
                case (s_r.cmd)
                    // (R09) register writes, flash regs pass when protected
                    `DCI_CMD_REGW: s_nxt.gate = !halted || (protect_i &&
                        (s_r.addr[11:0] < `DCI_FLASH_LO));
                    // (R11) program write needs unlock
                    `DCI_CMD_PMW: s_nxt.gate = locked || !flash_unlock_i;
                    // (R14) data read gated only by halt
                    `DCI_CMD_DMR: s_nxt.gate = !halted;
                    // (R10) (R12) (R13) (R21) other gated cases
                    default: s_nxt.gate = locked;
                endcase
                if (s_r.cnt == 17'd0) begin
                    s_nxt.st = DCI_IDLE;
                end else if (is_wr(s_r.cmd)) begin
                    if (s_r.busy) begin
                        s_nxt.req = 1'b0;
                        if (mem_ack_i) begin
                            s_nxt.busy = 1'b0;
                            s_nxt.addr = s_r.addr + 16'd1;
                            s_nxt.cnt = s_r.cnt - 17'd1;
                        end
                    end else if (rx_valid_i) begin
                        s_nxt.wd = rx_data_i;
                        // (R23) next byte, next address
                        if (s_nxt.gate) begin
                            s_nxt.addr = s_r.addr + 16'd1;
                            s_nxt.cnt = s_r.cnt - 17'd1;
                        end else begin
                            s_nxt.req = 1'b1;
                            s_nxt.we = 1'b1;
                            s_nxt.busy = 1'b1;
                        end
                    end
                end else if (!s_r.txv) begin
                    if (s_nxt.gate) begin
                        s_nxt.txv = 1'b1;
                        s_nxt.txd = `DCI_ALL_ONES;
                        s_nxt.addr = s_r.addr + 16'd1;
                        s_nxt.cnt = s_r.cnt - 17'd1;
                    end else if (!s_r.busy) begin
                        s_nxt.req = 1'b1;
                        s_nxt.we = 1'b0;
                        s_nxt.busy = 1'b1;
                    end else begin
                        s_nxt.req = 1'b0;
                        if (mem_ack_i) begin
                            s_nxt.busy = 1'b0;
                            s_nxt.txv = 1'b1;
                            s_nxt.txd = mem_rdata_i;
                            s_nxt.addr = s_r.addr + 16'd1;
                            s_nxt.cnt = s_r.cnt - 17'd1;
                        end
                    end
                end
            end
            DCI_REPLY: begin
                if (!s_r.txv) begin
                    if (s_r.nrep == 2'd0) begin
                        s_nxt.st = DCI_IDLE;
                    end else begin
                        s_nxt.txv = 1'b1;
                        s_nxt.txd = s_r.word[15:8];
                        s_nxt.word = {s_r.word[7:0], 8'h00};
                        s_nxt.nrep = s_r.nrep - 2'd1;
                    end
                end
            end
            DCI_CRC: begin
                // (R16) one program byte per access, reply after last
                if (s_r.cnt == 17'd0) begin
                    s_nxt.word = s_r.crc;
                    s_nxt.nrep = 2'd2;
                    s_nxt.st = DCI_REPLY;
                end else if (!s_r.busy) begin
                    s_nxt.req = 1'b1;
                    s_nxt.we = 1'b0;
                    s_nxt.busy = 1'b1;
                end else begin
                    s_nxt.req = 1'b0;
                    if (mem_ack_i) begin
                        s_nxt.busy = 1'b0;
                        s_nxt.crc = crc_upd;
                        s_nxt.addr = s_r.addr + 16'd1;
                        s_nxt.cnt = s_r.cnt - 17'd1;
                    end
                end
            end
            DCI_INSTR: begin
                // (R17) (R18) (R19) one instruction, wait for cpu
                if (!s_r.busy) begin
                    s_nxt.go = 1'b1;
                    s_nxt.busy = 1'b1;
                end else if (cpu_done_i) begin
                    s_nxt.busy = 1'b0;
                    s_nxt.st = DCI_IDLE;
                end
            end
            default: s_nxt.st = DCI_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
            s_r.st <= DCI_IDLE;
            s_r.ctl <= `DCI_CTL_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    // (R20) halt bit stops cpu fetch
    assign halt_o = halted;
    assign ctl_o = s_r.ctl;
    assign tx_valid_o = s_r.txv;
    assign tx_data_o = s_r.txd;
    assign pc_we_o = s_r.pcwe;
    assign pc_o = s_r.word;
    assign mem_req_o = s_r.req;
    assign mem_we_o = s_r.we;
    assign mem_addr_o = s_r.addr;
    assign mem_wdata_o = s_r.wd;
    assign mem_space_o = (s_r.st == DCI_CRC) ? DCI_SP_PROG :
        (s_r.cmd[7:1] == 7'h04) ? DCI_SP_REG :
        (s_r.cmd[7:1] == 7'h05) ? DCI_SP_PROG : DCI_SP_DATA;
    assign step_o = s_r.go && s_r.cmd == `DCI_CMD_STEP;
    assign stuff_o = s_r.go && s_r.cmd == `DCI_CMD_STUFF;
    assign exec_o = s_r.go && s_r.cmd == `DCI_CMD_EXEC;
    assign instr_o = s_r.ins;
    assign instr_len_o = s_r.ilen;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_prot_halt;
        @(posedge clk_i) disable iff (rst_i)
        (protect_i && halted) |=> halted;
    endproperty
    a_prot_halt: assert property (p_prot_halt) // (R04)
        else $error("halt bit cleared under protection");

    property p_pc_gate;
        @(posedge clk_i) disable iff (rst_i)
        pc_we_o |-> $past(halted) && !$past(protect_i);
    endproperty
    a_pc_gate: assert property (p_pc_gate) // (R06)
        else $error("pc written while gated");

    property p_step_gate;
        @(posedge clk_i) disable iff (rst_i)
        (step_o || exec_o || stuff_o) |-> halted;
    endproperty
    a_step_gate: assert property (p_step_gate) // (R17)
        else $error("instruction run while not halted");

    sequence s_ctlw;
        s_r.st == DCI_OPER && s_r.cmd == `DCI_CMD_CTLW && rx_valid_i
            && !protect_i;
    endsequence
    property p_ctlw;
        @(posedge clk_i) disable iff (rst_i)
        s_ctlw |=> ctl_o == $past(rx_data_i);
    endproperty
    a_ctlw: assert property (p_ctlw) // (R03)
        else $error("control write not loaded");

    property p_halt_out;
        @(posedge clk_i) disable iff (rst_i)
        (!halted && !(s_r.st == DCI_OPER && s_r.cmd == `DCI_CMD_CTLW
            && rx_valid_i)) |=> !halt_o;
    endproperty
    a_halt_out: assert property (p_halt_out) // (R20)
        else $error("halt set without control write");

    property p_wr_gate;
        @(posedge clk_i) disable iff (rst_i)
        (mem_req_o && mem_we_o) |-> halted;
    endproperty
    a_wr_gate: assert property (p_wr_gate) // (R09)
        else $error("memory write while running");

    property p_pm_read;
        @(posedge clk_i) disable iff (rst_i)
        (s_r.st == DCI_DATA && s_r.cmd == `DCI_CMD_PMR && protect_i)
            |-> !mem_req_o;
    endproperty
    a_pm_read: assert property (p_pm_read) // (R21)
        else $error("program read under protection");

    property p_tx_hold;
        @(posedge clk_i) disable iff (rst_i)
        (tx_valid_o && !tx_ready_i) |=> tx_valid_o && $stable(tx_data_o);
    endproperty
    a_tx_hold: assert property (p_tx_hold) // (R07)
        else $error("reply byte dropped");
endmodule

// ==== dci_sys_mdl.sv ====
// memory and cpu stand-in that answers the command interpreter
`timescale 1ns/10ps
module dci_sys_mdl (
    input  wire logic        clk_i,
    input  wire logic        mem_req_i,
    input  wire logic        mem_we_i,
    input  wire logic [15:0] mem_addr_i,
    input  wire logic [7:0]  mem_wdata_i,
    input  wire logic        run_i,
    output logic             mem_ack_o,
    output logic      [7:0]  mem_rdata_o,
    output logic             cpu_done_o,
    output logic      [23:0] wr_last_o
);
    logic [2:0] wait_r;
    logic [7:0] data_r;
    initial begin
        {wait_r, data_r, mem_ack_o, mem_rdata_o, cpu_done_o} = '0;
        wr_last_o = '0;
    end
    // ack after one or three cycles; data is junk outside the ack
    always @(posedge clk_i) begin
        mem_ack_o   <= 1'b0;
        mem_rdata_o <= ~mem_rdata_o;
        cpu_done_o  <= run_i;
        if (mem_req_i) begin
            wait_r <= {1'b0, mem_addr_i[0], 1'b1};
            data_r <= mem_addr_i[7:0] ^ 8'h3c;
            if (mem_we_i) begin
                wr_last_o <= {mem_addr_i, mem_wdata_i};
            end
        end else if (wait_r != 3'h0) begin
            wait_r <= wait_r - 3'h1;
            if (wait_r == 3'h1) begin
                mem_ack_o   <= 1'b1;
                mem_rdata_o <= data_r;
            end
        end
    end
endmodule

// ==== tb.sv ====
// self-checking bench for the debug command interpreter
`timescale 1ns/10ps
`include "dci_cfg.svh"
module tb;
    import dci_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, rx_valid_i = 1'b0, tx_ready_i = 1'b0;
    logic protect_i = 1'b0, unlock = 1'b0;
    logic [7:0] rx_data_i = 8'h00, status_i = 8'h5a, tx_data_o, ctl_o, wdata;
    logic [15:0] pc_i = 16'h1234, pc_o, addr, crc;
    logic tx_valid_o, halt_o, pc_we_o, req, we, ack, step_o, exec_o, stuff_o;
    logic done;
    logic [7:0] rdata;
    logic [39:0] instr_o;
    logic [2:0] instr_len_o;
    logic [23:0] wr_last;
    dci_space_t space;
    int err_count = 0, n_compared = 0, cyc = 0, i, n_run = 0, n_pcw = 0;
    dci_core #(.PM_AW(4)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
        .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
        .tx_ready_i(tx_ready_i), .protect_i(protect_i),
        .flash_unlock_i(unlock), .status_i(status_i), .halt_o(halt_o),
        .ctl_o(ctl_o), .pc_i(pc_i), .pc_we_o(pc_we_o), .pc_o(pc_o),
        .mem_req_o(req), .mem_we_o(we), .mem_space_o(space),
        .mem_addr_o(addr), .mem_wdata_o(wdata), .mem_ack_i(ack),
        .mem_rdata_i(rdata), .step_o(step_o), .exec_o(exec_o),
        .stuff_o(stuff_o), .instr_o(instr_o), .instr_len_o(instr_len_o),
        .cpu_done_i(done));
    dci_sys_mdl mdl (.clk_i(clk_i), .mem_req_i(req), .mem_we_i(we),
        .mem_addr_i(addr), .mem_wdata_i(wdata),
        .run_i(step_o | exec_o | stuff_o), .mem_ack_o(ack),
        .mem_rdata_o(rdata), .cpu_done_o(done), .wr_last_o(wr_last));
    initial forever #2 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        // count one-cycle instruction and pc load pulses
        if (step_o || exec_o || stuff_o) n_run <= n_run + 1;
        if (pc_we_o) n_pcw <= n_pcw + 1;
        if (cyc == 30000) begin
            err_count++;
            test_done();
        end
    end
    task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic send(logic [7:0] b);
        @(posedge clk_i);
        rx_valid_i <= 1'b1;
        rx_data_i  <= b;
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask
    // wait for a reply byte, compare it, then accept it
    task automatic recv(logic [7:0] exp);
        for (i = 0; i < 300; i++) begin
            @(negedge clk_i);
            if (tx_valid_o === 1'b1) break;
        end
        chk("reply valid", {23'h0, tx_valid_o}, 24'h1);
        chk("reply", {16'h0, tx_data_o}, {16'h0, exp});
        @(posedge clk_i) tx_ready_i <= 1'b1;
        @(posedge clk_i) tx_ready_i <= 1'b0;
    endtask
    task automatic t_basic();
        send(`DCI_CMD_REV); recv(8'(`DCI_REV_WORD >> 8));
        recv(8'(`DCI_REV_WORD));
        send(`DCI_CMD_STAT); recv(8'h5a);
        send(`DCI_CMD_PCR); recv(8'hff); recv(8'hff);
        send(`DCI_CMD_DMR); send(8'h01); send(8'h00); send(8'h00);
        send(8'h02); recv(8'hff); recv(8'hff);
        send(`DCI_CMD_STEP); repeat (20) @(negedge clk_i);
        chk("step idle", 24'(n_run), 24'h0);
    endtask
    task automatic t_halted();
        send(`DCI_CMD_CTLW); send(8'h80);
        chk("halt", {23'h0, halt_o}, 24'h1);
        send(`DCI_CMD_CTLR); recv(8'h80);
        send(`DCI_CMD_PCR); recv(8'h12); recv(8'h34);
        send(`DCI_CMD_PCW); send(8'hab); rx_data_i <= 8'hcd;
        rx_valid_i <= 1'b1; @(posedge clk_i) rx_valid_i <= 1'b0;
        for (i = 0; i < 20 && pc_we_o !== 1'b1; i++) @(negedge clk_i);
        chk("pc load", {8'h0, pc_o}, 24'h00abcd);
        chk("pc we", {23'h0, pc_we_o}, 24'h1);
        send(`DCI_CMD_DMR); send(8'h01); send(8'h00); send(8'h00);
        send(8'h02); recv(8'h3c); recv(8'h3d);
        send(`DCI_CMD_DMW); send(8'h02); send(8'h01); send(8'h00);
        send(8'h01); send(8'h77); repeat (10) @(posedge clk_i);
        chk("dm write", wr_last, 24'h020177);
        send(`DCI_CMD_REGW); send(8'h01); send(8'h23); send(8'h01);
        send(8'h55); repeat (10) @(posedge clk_i);
        chk("reg write", wr_last, 24'h012355);
        send(`DCI_CMD_STEP);
        chk("step", 24'(n_run), 24'h1);
        send(`DCI_CMD_STUFF); send(8'hab);
        chk("stuff", {instr_len_o, 13'h0, instr_o[7:0]}, 24'h2000ab);
        chk("stuff run", 24'(n_run), 24'h2);
    endtask
    // crc over the sixteen program bytes of the stand-in
    task automatic t_crc();
        crc = `DCI_CRC_INIT;
        for (int a = 0; a < 16; a++) begin
            for (int b = 7; b >= 0; b--) begin
                crc = (crc[15] ^ (a[7:0] ^ 8'h3c) >> b & 1'b1) ?
                    {crc[14:0], 1'b0} ^ `DCI_CRC_POLY : {crc[14:0], 1'b0};
            end
        end
        send(`DCI_CMD_CRC); recv(crc[15:8]); recv(crc[7:0]);
    endtask
    task automatic t_prot();
        protect_i <= 1'b1;
        send(`DCI_CMD_CTLW); send(8'h00);
        chk("halt kept", {23'h0, halt_o}, 24'h1);
        send(`DCI_CMD_PMR); send(8'h00); send(8'h00); send(8'h00);
        send(8'h01); recv(8'hff);
        send(`DCI_CMD_REGW); send(8'h0f); send(8'hf8); send(8'h01);
        send(8'haa); repeat (10) @(posedge clk_i);
        chk("flash reg", wr_last, 24'h0ff8aa);
        send(`DCI_CMD_REGW); send(8'h00); send(8'h10); send(8'h01);
        send(8'hbb); repeat (10) @(posedge clk_i);
        chk("reg drop", wr_last, 24'h0ff8aa);
        send(`DCI_CMD_PCW); send(8'h11); send(8'h22);
        chk("pc drop", 24'(n_pcw), 24'h1);
        send(`DCI_CMD_STEP); repeat (20) @(negedge clk_i);
        chk("step prot", 24'(n_run), 24'h2);
    endtask
    task automatic test_done();
        $display("compared %0d errors %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_basic();
        t_halted();
        t_crc();
        t_prot();
        test_done();
    end
endmodule
